// ---- irqpr_pkg.sv ----
package irqpr_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_REGS = 4;
    localparam int NUM_SRC = 19;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int FIELD_W = 2;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_SERIAL1_SPI = 6'h05;
    localparam logic [5:0] IDX_TIMER_C0_DECODER = 6'h06;
    localparam logic [5:0] IDX_TIMER_A0_TIMER_C = 6'h07;
    localparam logic [5:0] IDX_SERIAL0_TIMER_A = 6'h08;
    localparam logic [5:0] IDX_FIRST = IDX_SERIAL1_SPI;
    localparam logic [5:0] IDX_LAST = IDX_SERIAL0_TIMER_A;

    // reset value of every priority register, all sources disabled
    localparam logic [15:0] PRIO_RESET = 16'h0000;

    // writable bits per register, reserved bits are zero here
    localparam logic [15:0] WMASK [NUM_REGS] = '{
        16'h0f3f,
        16'hc00f,
        16'hc03f,
        16'hf3ff
    };

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] FIELD_OFF = 2'h0;
    localparam logic [1:0] FIELD_L0 = 2'h1;
    localparam logic [1:0] FIELD_L1 = 2'h2;
    localparam logic [1:0] FIELD_L2 = 2'h3;

    // ------------------------------------------------------------
    // source map: register slot and field low bit for each source
    // ------------------------------------------------------------
    // 0 port1_rx_full_level, 1 port1_rx_error_level, 2 port1_tx_idle_level,
    // 3 port1_tx_empty_level, 4 spi_zero_tx_empty_level, 5 timer_c_ch0_level,
    // 6 decoder_index_level, 7 decoder_home_watchdog_level, 8 timer_a_ch0_level,
    // 9 timer_c_ch3_level, 10 timer_c_ch2_level, 11 timer_c_ch1_level,
    // 12 port0_rx_full_level, 13 port0_rx_error_level, 14 port0_tx_idle_level,
    // 15 port0_tx_empty_level, 16 timer_a_ch3_level, 17 timer_a_ch2_level,
    // 18 timer_a_ch1_level
    localparam int SRC_SLOT [NUM_SRC] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
    localparam int SRC_POS [NUM_SRC] = '{10, 8, 4, 2, 0, 14, 2, 0, 14, 4, 2, 0, 14, 12, 8, 6, 4, 2, 0};

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // byte address of a register index
    function automatic logic [7:0] idx_to_addr(input logic [5:0] idx);
        idx_to_addr = {idx, 2'b00};
    endfunction

    // address decode: {hit, slot}
    function automatic logic [2:0] addr_slot(input logic [7:0] addr);
        logic [5:0] off;
        off = addr[7:2] - IDX_FIRST;
        if (addr[1:0] == 2'b00 && addr[7:2] >= IDX_FIRST && addr[7:2] <= IDX_LAST) begin
            addr_slot = {1'b1, off[1:0]};
        end else begin
            addr_slot = 3'b000;
        end
    endfunction

endpackage

// ---- irqpr_reg_merge.sv ----
`timescale 1ns/100ps
`default_nettype none

module irqpr_reg_merge
    import irqpr_pkg::*;
(
    // current state and write data
    input wire logic [15:0] cur,
    input wire logic [15:0] wdata,
    input wire logic [1:0] wstrb,
    input wire logic [15:0] wmask,
    // merged next value
    output logic [15:0] nxt
);

    logic [15:0] lane_mask;

    // only enabled byte lanes and writable bits change
    assign lane_mask = {{8{wstrb[1]}}, {8{wstrb[0]}}} & wmask;
    assign nxt = (cur & ~lane_mask) | (wdata & lane_mask);

endmodule

`default_nettype wire

// ---- irqpr_level_decode.sv ----
`timescale 1ns/100ps
`default_nettype none

module irqpr_level_decode
    import irqpr_pkg::*;
(
    // field and pending request
    input wire logic [1:0] field,
    input wire logic req,
    // decoded outputs
    output logic en,
    output logic lvl0,
    output logic lvl1,
    output logic lvl2
);

    // map the field to one of three levels or off
    always_comb begin
        en = 1'b0;
        lvl0 = 1'b0;
        lvl1 = 1'b0;
        lvl2 = 1'b0;
        case (field)
            FIELD_L0: begin
                en = 1'b1;
                lvl0 = req;
            end
            FIELD_L1: begin
                en = 1'b1;
                lvl1 = req;
            end
            FIELD_L2: begin
                en = 1'b1;
                lvl2 = req;
            end
            default: begin
                en = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ---- irqpr_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module irqpr_top
    import irqpr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pending requests from the peripherals
    input wire logic [18:0] src_req,
    // forwarded requests per level and enable state
    output logic [18:0] fwd_lvl0,
    output logic [18:0] fwd_lvl1,
    output logic [18:0] fwd_lvl2,
    output logic [18:0] src_enabled
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] prio_q [NUM_REGS];
    logic [15:0] prio_d [NUM_REGS];
    logic aw_held_q, w_held_q;
    logic [7:0] awaddr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [2:0] wr_dec, rd_dec;
    logic wr_fire;
    logic [31:0] rd_word;
    logic [18:0] dec_en, dec_l0, dec_l1, dec_l2;
    logic [18:0] fwd_lvl0_q, fwd_lvl1_q, fwd_lvl2_q, src_enabled_q;

    assign wr_dec = addr_slot(awaddr_q);
    assign rd_dec = addr_slot(araddr);
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

    // ------------------------------------------------------------
    // write address channel
    // ------------------------------------------------------------
    // address held until the response has been taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            awready_q <= 1'b0;
        end else if (awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awaddr_q <= awaddr;
            awready_q <= 1'b0;
        end else if (bvalid_q && bready) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end else if (!aw_held_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // write data channel
    // ------------------------------------------------------------
    // data held until the response has been taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'b00;
            wready_q <= 1'b0;
        end else if (wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wdata_q <= wdata[15:0];
            wstrb_q <= wstrb[1:0];
            wready_q <= 1'b0;
        end else if (bvalid_q && bready) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end else if (!w_held_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // write response channel
    // ------------------------------------------------------------
    // unmapped or misaligned addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_dec[2] ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // priority registers
    // ------------------------------------------------------------
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
        irqpr_reg_merge u_merge (
            .cur(prio_q[r]),
            .wdata(wdata_q),
            .wstrb(wstrb_q),
            .wmask(WMASK[r]),
            .nxt(prio_d[r])
        );

        // update on a committed write to this slot
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                prio_q[r] <= PRIO_RESET;
            end else if (wr_fire && wr_dec[2] && wr_dec[1:0] == 2'(r)) begin
                prio_q[r] <= prio_d[r];
            end
        end
    end

    // ------------------------------------------------------------
    // read channels
    // ------------------------------------------------------------
    // reserved bits and upper half read as zero
    assign rd_word = rd_dec[2] ? {16'h0000, prio_q[rd_dec[1:0]] & WMASK[rd_dec[1:0]]} : 32'h0000_0000;

    // one read under way at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_dec[2] ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // level decode and forwarding
    // ------------------------------------------------------------
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
        irqpr_level_decode u_dec (
            .field(prio_q[SRC_SLOT[s]][SRC_POS[s] +: FIELD_W]),
            .req(src_req[s]),
            .en(dec_en[s]),
            .lvl0(dec_l0[s]),
            .lvl1(dec_l1[s]),
            .lvl2(dec_l2[s])
        );
    end

    // forwarded requests registered towards arbitration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_lvl0_q <= 19'h0_0000;
            fwd_lvl1_q <= 19'h0_0000;
            fwd_lvl2_q <= 19'h0_0000;
            src_enabled_q <= 19'h0_0000;
        end else begin
            fwd_lvl0_q <= dec_l0;
            fwd_lvl1_q <= dec_l1;
            fwd_lvl2_q <= dec_l2;
            src_enabled_q <= dec_en;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign fwd_lvl0 = fwd_lvl0_q;
    assign fwd_lvl1 = fwd_lvl1_q;
    assign fwd_lvl2 = fwd_lvl2_q;
    assign src_enabled = src_enabled_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_aw_w_taken;
        awvalid && awready_q && wvalid && wready_q;
    endsequence

    sequence s_full_write_slot0;
        s_aw_w_taken ##0 (awaddr == idx_to_addr(IDX_SERIAL1_SPI) && wdata[15:0] == 16'hffff && wstrb[1:0] == 2'b11);
    endsequence

    property p_reset_clear;
        @(posedge aclk) !aresetn |=> (prio_q[0] == PRIO_RESET && prio_q[1] == PRIO_RESET &&
            prio_q[2] == PRIO_RESET && prio_q[3] == PRIO_RESET && fwd_lvl0_q == 19'h0_0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("registers not clear after reset");

    property p_reserved_zero;
        @(posedge aclk) disable iff (!aresetn)
        ((prio_q[0] & ~WMASK[0]) | (prio_q[1] & ~WMASK[1]) | (prio_q[2] & ~WMASK[2]) |
            (prio_q[3] & ~WMASK[3])) == 16'h0000 && (!rvalid_q || rdata_q[31:16] == 16'h0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_full_write;
        @(posedge aclk) disable iff (!aresetn)
        s_full_write_slot0 |-> ##2 (prio_q[0] == WMASK[0] && bvalid_q && bresp_q == RESP_OKAY);
    endproperty
    a_full_write: assert property (p_full_write) else $error("offset 5 write did not land");

    property p_read_answer;
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready_q) |=> (rvalid_q && rdata_q == $past(rd_word));
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer wrong or late");

    property p_level0;
        @(posedge aclk) disable iff (!aresetn)
        (src_req[0] && prio_q[0][11:10] == FIELD_L0) |=> (fwd_lvl0_q[0] && !fwd_lvl1_q[0] && !fwd_lvl2_q[0]);
    endproperty
    a_level0: assert property (p_level0) else $error("level 0 not forwarded");

    property p_index_level1;
        @(posedge aclk) disable iff (!aresetn)
        (src_req[6] && prio_q[1][3:2] == FIELD_L1) |=> (fwd_lvl1_q[6] && src_enabled_q[6]);
    endproperty
    a_index_level1: assert property (p_index_level1) else $error("decoder index not at level 1");

    property p_one_level;
        @(posedge aclk) disable iff (!aresetn)
        ((fwd_lvl0_q & fwd_lvl1_q) | (fwd_lvl0_q & fwd_lvl2_q) | (fwd_lvl1_q & fwd_lvl2_q)) == 19'h0_0000;
    endproperty
    a_one_level: assert property (p_one_level) else $error("source on two levels");

    property p_level2;
        @(posedge aclk) disable iff (!aresetn)
        (src_req[18] && prio_q[3][1:0] == FIELD_L2) |=> fwd_lvl2_q[18];
    endproperty
    a_level2: assert property (p_level2) else $error("level 2 not forwarded");

    property p_disabled_quiet;
        @(posedge aclk) disable iff (!aresetn)
        (prio_q[1][15:14] == FIELD_OFF) |=> (!fwd_lvl0_q[5] && !fwd_lvl1_q[5] && !fwd_lvl2_q[5] && !src_enabled_q[5]);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source forwarded");

    property p_no_spurious;
        @(posedge aclk) disable iff (!aresetn)
        ##1 ((fwd_lvl0_q | fwd_lvl1_q | fwd_lvl2_q) & ~$past(src_req)) == 19'h0_0000;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("forward without request");

endmodule

`default_nettype wire

// ---- irqpr_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module irqpr_top_tb
    import irqpr_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic [2:0] awprot;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic [2:0] arprot;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic [18:0] src_req;
    logic [18:0] fwd_lvl0;
    logic [18:0] fwd_lvl1;
    logic [18:0] fwd_lvl2;
    logic [18:0] src_enabled;
    int n_mismatch = 0;
    int compares = 0;

    // byte addresses, writable bits, and the slot and low bit of each source
    localparam logic [7:0] REG_ADDR [4] = '{8'h14, 8'h18, 8'h1c, 8'h20};
    localparam logic [15:0] REG_MASK [4] = '{16'h0f3f, 16'hc00f, 16'hc03f, 16'hf3ff};
    localparam int SLOT [19] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
    localparam int POS [19] = '{10, 8, 4, 2, 0, 14, 2, 0, 14, 4, 2, 0, 14, 12, 8, 6, 4, 2, 0};

    // ----------------------------------------------------------------
    // clock and device
    // ----------------------------------------------------------------
    initial aclk = 1'b0;
    always #4 aclk = ~aclk;

    irqpr_top i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .src_req(src_req), .fwd_lvl0(fwd_lvl0), .fwd_lvl1(fwd_lvl1), .fwd_lvl2(fwd_lvl2),
        .src_enabled(src_enabled)
    );

    // ----------------------------------------------------------------
    // compares and verdict
    // ----------------------------------------------------------------
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_vec(input string what, input logic [18:0] exp, input logic [18:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // bus cycles: each starts one edge on so no signal is driven twice
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        if (n >= 50) begin
            awvalid <= 1'b0;
            wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check_word("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        if (n >= 50) arvalid <= 1'b0;
        rready <= 1'b0;
        check_word("rdata", {16'h0000, exp}, rdata);
        check_word("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // every register and every source starts disabled
    task automatic t_reset_values();
        for (int i = 0; i < 4; i++) rd(REG_ADDR[i], 16'h0000, RESP_OKAY);
        src_req <= '1;
        repeat (2) @(posedge aclk);
        check_vec("src_enabled", 19'h0, src_enabled);
        check_vec("fwd_any", 19'h0, fwd_lvl0 | fwd_lvl1 | fwd_lvl2);
        check_word("bus_idle", 32'h0000_001c, {27'h0, awready, wready, arready, bvalid, rvalid});
        src_req <= '0;
    endtask

    // all ones written: only field bits stick, reserved read zero
    task automatic t_reserved();
        for (int i = 0; i < 4; i++) begin
            wr(REG_ADDR[i], 16'hffff, 4'hf, RESP_OKAY);
            rd(REG_ADDR[i], REG_MASK[i], RESP_OKAY);
            wr(REG_ADDR[i], 16'h0000, 4'hf, RESP_OKAY);
            rd(REG_ADDR[i], 16'h0000, RESP_OKAY);
        end
    endtask

    // every code of every field, with requests pending and then idle
    task automatic t_fields();
        logic [15:0] v;
        logic [18:0] b;
        for (int s = 0; s < 19; s++) begin
            b = 19'h1 << s;
            for (int c = 0; c < 4; c++) begin
                v = 16'(c) << POS[s];
                wr(REG_ADDR[SLOT[s]], v, 4'hf, RESP_OKAY);
                rd(REG_ADDR[SLOT[s]], v, RESP_OKAY);
                src_req <= '1;
                repeat (2) @(posedge aclk);
                check_vec("src_enabled", (c != 0) ? b : 19'h0, src_enabled);
                check_vec("fwd_lvl0", (c == 1) ? b : 19'h0, fwd_lvl0);
                check_vec("fwd_lvl1", (c == 2) ? b : 19'h0, fwd_lvl1);
                check_vec("fwd_lvl2", (c == 3) ? b : 19'h0, fwd_lvl2);
                src_req <= '0;
                repeat (2) @(posedge aclk);
                check_vec("fwd_idle", 19'h0, fwd_lvl0 | fwd_lvl1 | fwd_lvl2);
            end
            wr(REG_ADDR[SLOT[s]], 16'h0000, 4'hf, RESP_OKAY);
        end
    endtask

    // byte lanes gate the low and high halves separately
    task automatic t_strobes();
        wr(8'h20, 16'hffff, 4'h1, RESP_OKAY);
        rd(8'h20, 16'h00ff, RESP_OKAY);
        wr(8'h20, 16'hff00, 4'h2, RESP_OKAY);
        rd(8'h20, 16'hf3ff, RESP_OKAY);
        wr(8'h20, 16'h0000, 4'hc, RESP_OKAY);
        rd(8'h20, 16'hf3ff, RESP_OKAY);
        wr(8'h20, 16'h0000, 4'hf, RESP_OKAY);
    endtask

    // neighbours and misaligned addresses are refused and change nothing
    task automatic t_unmapped();
        logic [7:0] bad [3];
        bad = '{8'h10, 8'h24, 8'h15};
        for (int i = 0; i < 3; i++) begin
            wr(bad[i], 16'hffff, 4'hf, RESP_SLVERR);
            rd(bad[i], 16'h0000, RESP_SLVERR);
        end
        rd(8'h14, 16'h0000, RESP_OKAY);
        rd(8'h20, 16'h0000, RESP_OKAY);
    endtask

    // a reset in mid run clears fields set by software
    task automatic t_mid_reset();
        for (int i = 0; i < 4; i++) wr(REG_ADDR[i], 16'hffff, 4'hf, RESP_OKAY);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check_vec("src_enabled", 19'h0, src_enabled);
        for (int i = 0; i < 4; i++) rd(REG_ADDR[i], 16'h0000, RESP_OKAY);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        aresetn = 1'b0;
        awaddr = '0;
        awprot = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arprot = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        src_req = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset_values();
        t_reserved();
        t_fields();
        t_strobes();
        t_unmapped();
        t_mid_reset();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        give_verdict();
    end

endmodule

`default_nettype wire
